/* File: rtl/dms_pkg.sv */
// Purpose: shared constants and types for the mode/strap pin logic
// Assumes: 40 MHz clk, APB slave with 32-bit data
// Notes: serial frame is 8 instruction bits then 8 data bits, msb first
package dms_pkg;

  localparam int DATA_W = 14;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;

  localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004;
  localparam logic [APB_AW-1:0] ADDR_SPIREG = 12'h008;
  localparam logic [APB_AW-1:0] ADDR_DATA = 12'h00c;

  localparam int CTRL_SHARED_BIT = 0;
  localparam logic CTRL_SHARED_RST = 1'h0;

  // serial configuration space
  localparam int SPI_RW_W = 8;
  localparam int SPI_NREG = 4;
  localparam int SPI_IDX_W = 2;
  localparam logic [2:0] SPI_LAST_BIT = 3'h7;
  localparam int SPI_RW_POS = 7;
  localparam logic [6:0] SPI_NREG_ADDR = 7'h04;
  localparam logic [SPI_RW_W-1:0] SPI_DEF0 = 8'h00;
  localparam logic [SPI_RW_W-1:0] SPI_DEF1 = 8'h00;
  localparam logic [SPI_RW_W-1:0] SPI_DEF2 = 8'h00;
  localparam logic [SPI_RW_W-1:0] SPI_DEF3 = 8'h00;

  // fields of serial register 0
  localparam int CFG_FMT_BIT = 0;
  localparam int CFG_PD_BIT = 1;
  localparam int CFG_Q_INTERNAL_SCALE_RESISTOR_BIT = 2;
  localparam int CFG_I_INTERNAL_SCALE_RESISTOR_BIT = 3;
  localparam int CFG_PHASE_BIT = 4;

  // synchronised pin vector positions
  localparam int PIN_MSR = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SDIO = 2;
  localparam int PIN_CS = 3;
  localparam int PIN_DCLK = 4;
  localparam int PIN_SCLKIN = 5;
  localparam int PIN_N = 6;

  typedef struct packed {
    logic twos;
    logic pd;
    logic q_aux;
    logic i_aux;
    logic phase;
  } dms_cfg_t;

  typedef enum {
    SPI_IDLE, SPI_INSTR, SPI_WDATA, SPI_RDATA, SPI_DONE
  } dms_spi_st_t;

  function automatic logic [DATA_W-1:0] dms_to_binary(
    input logic [DATA_W-1:0] w, input logic twos);
    dms_to_binary = w ^ {twos, {(DATA_W-1){1'b0}}};
  endfunction

  function automatic logic dms_is_map(input logic [APB_AW-1:0] a);
    dms_is_map = (a == ADDR_CTRL) || (a == ADDR_STATUS) ||
                 (a == ADDR_SPIREG) || (a == ADDR_DATA);
  endfunction

endpackage

/* File: rtl/dms_sync.sv */
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes: output changes only when stages two and three agree
`timescale 1ns/10ps
module dms_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [W-1:0] lvl_d;

  // stage one feeds stage two only
  always_comb begin
    lvl_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else if (clk_en) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;
endmodule // dms_sync

/* File: rtl/dms_edge.sv */
// Purpose: rise and fall pulses from synchronised levels
// Assumes: levels already in clk domain
// Notes: pulses last one enabled cycle
`timescale 1ns/10ps
module dms_edge #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= '0;
    end else if (clk_en) begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q & {W{clk_en}};
  assign fall = ~level & prev_q & {W{clk_en}};
endmodule // dms_edge

/* File: rtl/dms_mode_ctl.sv */
// Purpose: mode decode, shared pin functions, serial port, strap data path
// Assumes: link pins asynchronous; link clock well below clk/4
// Notes: registers reached over APB; pready low while clk_en is low
`timescale 1ns/10ps
module dms_mode_ctl
  import dms_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_select_reset,
  input wire logic sclk_phase_pin,
  input wire logic sdio_format_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  input wire logic cs_n_power_down_pin,
  input wire logic data_clock,
  input wire logic sampling_clock,
  input wire logic [DATA_W-1:0] data_in,
  output logic serial_mode,
  output logic power_down,
  output logic twos_complement,
  output logic q_pin_is_aux,
  output logic i_pin_is_aux,
  output logic retime_phase,
  output logic retime_trigger,
  output logic word_valid,
  output logic [DATA_W-1:0] conv_word,
  output logic conv_strobe
);

  logic [PIN_N-1:0] pin_raw, pin_lvl, pin_rise, pin_fall;
  logic [DATA_W-1:0] data_lvl;

  assign pin_raw = {sampling_clock, data_clock, cs_n_power_down_pin,
                    sdio_format_in, sclk_phase_pin, mode_select_reset};

  // straps resynchronised before use
  dms_sync #(.W(PIN_N)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(pin_raw),
    .level_out(pin_lvl)
  );

  // data bits take the same delay as the data clock
  dms_sync #(.W(DATA_W)) u_data_sync (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(data_in),
    .level_out(data_lvl)
  );

  dms_edge #(.W(PIN_N)) u_edge (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  logic pin_mode;
  logic sclk_rise, sclk_fall, cs_n_lvl;

  assign pin_mode = pin_lvl[PIN_MSR];
  assign sclk_rise = pin_rise[PIN_SCLK];
  assign sclk_fall = pin_fall[PIN_SCLK];
  assign cs_n_lvl = pin_lvl[PIN_CS];

  // serial configuration port
  dms_spi_st_t spi_st_q, spi_st_d;
  logic [2:0] bit_q, bit_d;
  logic [SPI_RW_W-1:0] ins_q, ins_d;
  logic [SPI_RW_W-1:0] sh_q, sh_d;
  logic [SPI_RW_W-1:0] spi_reg_q [SPI_NREG];
  logic [SPI_RW_W-1:0] spi_reg_d [SPI_NREG];
  logic spi_wr;
  logic [SPI_IDX_W-1:0] spi_idx;
  logic spi_hit;
  logic [SPI_RW_W-1:0] ins_next;

  assign ins_next = {ins_q[SPI_RW_W-2:0], pin_lvl[PIN_SDIO]};
  assign spi_idx = ins_q[SPI_IDX_W-1:0];
  assign spi_hit = (ins_q[6:0] < SPI_NREG_ADDR);

  always_comb begin
    spi_st_d = spi_st_q;
    bit_d = bit_q;
    ins_d = ins_q;
    sh_d = sh_q;
    spi_wr = 1'b0;
    if (pin_mode || cs_n_lvl) begin
      // deselect ends any frame; chip select is active low
      spi_st_d = SPI_IDLE;
      bit_d = '0;
    end else begin
      case (spi_st_q)
        SPI_IDLE: begin
          spi_st_d = SPI_INSTR;
          bit_d = '0;
        end
        SPI_INSTR: begin
          if (sclk_rise) begin
            ins_d = ins_next;
            bit_d = bit_q + 3'h1;
            if (bit_q == SPI_LAST_BIT) begin
              bit_d = '0;
              if (ins_next[SPI_RW_POS]) begin
                spi_st_d = SPI_RDATA;
                sh_d = (ins_next[6:0] < SPI_NREG_ADDR) ?
                       spi_reg_q[ins_next[SPI_IDX_W-1:0]] : '0;
              end else begin
                spi_st_d = SPI_WDATA;
              end
            end
          end
        end
        SPI_WDATA: begin
          if (sclk_rise) begin
            sh_d = {sh_q[SPI_RW_W-2:0], pin_lvl[PIN_SDIO]};
            bit_d = bit_q + 3'h1;
            if (bit_q == SPI_LAST_BIT) begin
              spi_wr = spi_hit;
              spi_st_d = SPI_DONE;
            end
          end
        end
        SPI_RDATA: begin
          if (sclk_fall) begin
            sh_d = {sh_q[SPI_RW_W-2:0], 1'b0};
            bit_d = bit_q + 3'h1;
            if (bit_q == SPI_LAST_BIT) begin
              spi_st_d = SPI_DONE;
            end
          end
        end
        SPI_DONE: begin
          spi_st_d = SPI_DONE;
        end
        default: begin
          spi_st_d = SPI_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < SPI_NREG; i++) begin
      spi_reg_d[i] = spi_reg_q[i];
    end
    if (spi_wr) begin
      spi_reg_d[spi_idx] = {sh_q[SPI_RW_W-2:0], pin_lvl[PIN_SDIO]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      spi_st_q <= SPI_IDLE;
      bit_q <= '0;
      ins_q <= '0;
      sh_q <= '0;
    end else if (clk_en) begin
      spi_st_q <= spi_st_d;
      bit_q <= bit_d;
      ins_q <= ins_d;
      sh_q <= sh_d;
    end
  end

  // a high mode pin, pulsed or held, restores defaults
  always_ff @(posedge clk) begin
    if (rst) begin
      spi_reg_q[0] <= SPI_DEF0;
      spi_reg_q[1] <= SPI_DEF1;
      spi_reg_q[2] <= SPI_DEF2;
      spi_reg_q[3] <= SPI_DEF3;
    end else if (clk_en) begin
      if (pin_mode) begin
        spi_reg_q[0] <= SPI_DEF0;
        spi_reg_q[1] <= SPI_DEF1;
        spi_reg_q[2] <= SPI_DEF2;
        spi_reg_q[3] <= SPI_DEF3;
      end else begin
        spi_reg_q <= spi_reg_d;
      end
    end
  end

  // device drives the line only while shifting read data
  assign sdio_oe_n = !(spi_st_q == SPI_RDATA);
  assign sdio_out = sh_q[SPI_RW_W-1];

  // retime phase, pin mode edge trigger
  logic ctrl_shared_q, ctrl_shared_d;
  logic phase_q, phase_d;
  logic trig_q, trig_d;

  always_comb begin
    phase_d = phase_q;
    trig_d = 1'b0;
    if (!pin_mode) begin
      phase_d = spi_reg_q[0][CFG_PHASE_BIT];
    end else if (ctrl_shared_q) begin
      // host holds the strap low here; nothing to align
      phase_d = 1'b0;
    end else if (sclk_rise) begin
      // capture where the sampling clock stands at the strap edge
      phase_d = pin_lvl[PIN_SCLKIN];
      trig_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= 1'b0;
      trig_q <= 1'b0;
    end else if (clk_en) begin
      phase_q <= phase_d;
      trig_q <= trig_d;
    end
  end

  // effective configuration per mode
  dms_cfg_t cfg;

  always_comb begin
    if (pin_mode) begin
      cfg.twos = pin_lvl[PIN_SDIO];
      cfg.pd = pin_lvl[PIN_CS];
    end else begin
      cfg.twos = spi_reg_q[0][CFG_FMT_BIT];
      cfg.pd = spi_reg_q[0][CFG_PD_BIT];
    end
    cfg.q_aux = spi_reg_q[0][CFG_Q_INTERNAL_SCALE_RESISTOR_BIT];
    cfg.i_aux = spi_reg_q[0][CFG_I_INTERNAL_SCALE_RESISTOR_BIT];
    cfg.phase = phase_q;
  end

  // data path: data clock qualifies, sampling clock converts
  logic [DATA_W-1:0] word_q, word_d, conv_q, conv_d;
  logic wvld_q, wvld_d, cstb_q, cstb_d;

  always_comb begin
    word_d = word_q;
    conv_d = conv_q;
    wvld_d = 1'b0;
    cstb_d = 1'b0;
    // power-down freezes the path; serial port keeps running
    if (!cfg.pd) begin
      if (pin_rise[PIN_DCLK]) begin
        word_d = data_lvl;
        wvld_d = 1'b1;
      end
      if (pin_rise[PIN_SCLKIN]) begin
        conv_d = dms_to_binary(word_q, cfg.twos);
        cstb_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      word_q <= '0;
      conv_q <= '0;
      wvld_q <= 1'b0;
      cstb_q <= 1'b0;
    end else if (clk_en) begin
      word_q <= word_d;
      conv_q <= conv_d;
      wvld_q <= wvld_d;
      cstb_q <= cstb_d;
    end
  end

  // APB slave
  logic setup, access;
  logic [APB_DW-1:0] rd_q, rd_d;
  logic [APB_DW-1:0] status;

  assign setup = psel && !penable && clk_en;
  assign access = psel && penable && clk_en;

  always_comb begin
    status = '0;
    status[0] = !pin_mode;
    status[1] = cfg.twos;
    status[2] = cfg.pd;
    status[3] = cfg.q_aux;
    status[4] = cfg.i_aux;
    status[5] = cfg.phase;
    status[6] = !cs_n_lvl && !pin_mode;
  end

  always_comb begin
    rd_d = rd_q;
    ctrl_shared_d = ctrl_shared_q;
    if (setup) begin
      case (paddr)
        ADDR_CTRL: rd_d = {{(APB_DW-1){1'b0}}, ctrl_shared_q};
        ADDR_STATUS: rd_d = status;
        ADDR_SPIREG: rd_d = {spi_reg_q[3], spi_reg_q[2],
                             spi_reg_q[1], spi_reg_q[0]};
        ADDR_DATA: rd_d = {{(APB_DW-DATA_W){1'b0}}, conv_q};
        default: rd_d = '0;
      endcase
    end
    if (access && pwrite && (paddr == ADDR_CTRL)) begin
      ctrl_shared_d = pwdata[CTRL_SHARED_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= '0;
      ctrl_shared_q <= CTRL_SHARED_RST;
    end else if (clk_en) begin
      rd_q <= rd_d;
      ctrl_shared_q <= ctrl_shared_d;
    end
  end

  assign prdata = rd_q;
  assign pready = clk_en;
  // status, spi view and data are read only
  assign pslverr = psel && penable &&
                   (!dms_is_map(paddr) ||
                    (pwrite && (paddr != ADDR_CTRL)));

  // outputs
  assign serial_mode = !pin_mode;
  assign power_down = cfg.pd;
  assign twos_complement = cfg.twos;
  assign q_pin_is_aux = cfg.q_aux;
  assign i_pin_is_aux = cfg.i_aux;
  assign retime_phase = phase_q;
  assign retime_trigger = trig_q;
  assign word_valid = wvld_q;
  assign conv_word = conv_q;
  assign conv_strobe = cstb_q;

endmodule // dms_mode_ctl

/* File: dv/dms_checker.sv */
// Purpose: port checks of mode decode and strap pins
// Assumes: clk_en held high
// Notes: pin filter settles well inside 8 cycles
`timescale 1ns/10ps
module dms_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic mode_select_reset,
  input wire logic sclk_phase_pin,
  input wire logic sdio_format_in,
  input wire logic sdio_oe_n,
  input wire logic cs_n_power_down_pin,
  input wire logic data_clock,
  input wire logic sampling_clock,
  input wire logic serial_mode,
  input wire logic power_down,
  input wire logic twos_complement,
  input wire logic q_pin_is_aux,
  input wire logic i_pin_is_aux,
  input wire logic retime_trigger,
  input wire logic word_valid,
  input wire logic conv_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_pin;
    mode_select_reset [*8];
  endsequence
  sequence s_quiet(sig);
    !sig [*8];
  endsequence
  a_serial_sel: assert property
    (s_quiet(mode_select_reset) |-> serial_mode)
    else $error("serial mode missing");
  a_pin_sel: assert property
    (s_pin |-> !serial_mode)
    else $error("pin mode missing");
  a_pin_no_aux: assert property
    (s_pin |-> ##2 (!q_pin_is_aux && !i_pin_is_aux))
    else $error("aux pin in pin mode");
  a_fmt_twos: assert property
    ((mode_select_reset && sdio_format_in) [*8] |-> twos_complement)
    else $error("format strap ignored");
  a_pd_strap: assert property
    ((mode_select_reset && cs_n_power_down_pin) [*8] |-> power_down)
    else $error("power-down strap ignored");
  a_sdio_idle: assert property
    (cs_n_power_down_pin [*8] |-> sdio_oe_n)
    else $error("data line driven unselected");
  a_trig_pin: assert property
    (retime_trigger |-> !serial_mode)
    else $error("retime in serial mode");
  a_trig_edge: assert property
    (s_quiet(sclk_phase_pin) |-> !retime_trigger)
    else $error("retime without edge");
  a_word_qual: assert property
    (s_quiet(data_clock) |-> !word_valid)
    else $error("word without data clock");
  a_conv_pace: assert property
    (s_quiet(sampling_clock) |-> !conv_strobe)
    else $error("strobe without sampling clock");
endmodule // dms_checker

bind dms_mode_ctl dms_checker i_dms_checker (.*);

/* File: dv/dms_host_model.sv */
// Purpose: host side of shared pins: straps, mode pulse, serial frames
// Assumes: serial clock period 8 clk (200 ns)
// Notes: released data line toggles so stale bits cannot pass
`timescale 1ns/10ps
module dms_host_model (
  input wire logic clk,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  output logic mode_select_reset,
  output logic sclk_phase_pin,
  output logic cs_n_power_down_pin,
  output logic sdio_format_in
);
  logic host_d = 1'b0;
  initial begin
    mode_select_reset = 1'b0;
    sclk_phase_pin = 1'b0;
    cs_n_power_down_pin = 1'b1;
  end
  assign sdio_format_in = sdio_oe_n ? host_d : sdio_out;
  task automatic strap(input logic m, p, f, d);
    @(posedge clk) begin
      mode_select_reset <= m;
      sclk_phase_pin <= p;
      host_d <= f;
      cs_n_power_down_pin <= d;
    end
  endtask
  task automatic pulse();
    @(posedge clk) mode_select_reset <= 1'b1;
    repeat (8) @(posedge clk);
    mode_select_reset <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task automatic frame(input logic [15:0] tx, output logic [7:0] rx);
    rx = '0;
    @(posedge clk) cs_n_power_down_pin <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk) begin
        sclk_phase_pin <= 1'b0;
        host_d <= (tx[15] && i < 8) ? ~host_d : tx[i];
      end
      repeat (3) @(posedge clk);
      // read bit stands until the device sees the next fall
      @(negedge clk) if (i < 8) rx[i] = sdio_format_in;
      @(posedge clk) sclk_phase_pin <= 1'b1;
      repeat (3) @(posedge clk);
    end
    @(posedge clk) sclk_phase_pin <= 1'b0;
    repeat (8) @(posedge clk);
    cs_n_power_down_pin <= 1'b1;
    host_d <= ~host_d;
    repeat (12) @(posedge clk);
  endtask
endmodule // dms_host_model

/* File: dv/dms_mode_ctl_bench.sv */
// Purpose: self-checking bench of the mode and strap pin logic
// Assumes: clk_en tied high, so pready answers at once
// Notes: settle windows of 16 cycles cover the pin filter
`timescale 1ns/10ps
module dms_mode_ctl_bench;
  import dms_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0;
  logic [APB_DW-1:0] prdata;
  logic pready, pslverr, mode_select_reset, sclk_phase_pin, sdio_format_in;
  logic sdio_out, sdio_oe_n, cs_n_power_down_pin, serial_mode, power_down;
  logic twos_complement, q_pin_is_aux, i_pin_is_aux, retime_phase;
  logic retime_trigger, word_valid, conv_strobe;
  logic data_clock = 1'b0;
  logic sampling_clock = 1'b0;
  logic [DATA_W-1:0] data_in = '0;
  logic [DATA_W-1:0] conv_word;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  dms_mode_ctl i_dms_mode_ctl (.*);
  dms_host_model i_dms_host_model (.*);
  initial forever #12.5 clk = ~clk;
  task automatic conclude();
    $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // runaway guard, far above the roughly 1130 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk) begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
    end
    @(posedge clk) penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reg_is(input logic [11:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, '0, r, e);
    chk("read data", r, x);
    chk("read error", 32'(e), 32'(xe));
  endtask
  task automatic count16(output int t, w, c);
    t = 0;
    w = 0;
    c = 0;
    repeat (16) begin
      @(negedge clk);
      if (retime_trigger === 1'b1) t++;
      if (word_valid === 1'b1) w++;
      if (conv_strobe === 1'b1) c++;
    end
  endtask
  task automatic pins(input logic m, p, f, d, output int t, w, c);
    i_dms_host_model.strap(m, p, f, d);
    count16(t, w, c);
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    reg_is(ADDR_CTRL, 32'h0, 1'b0);
    reg_is(ADDR_STATUS, 32'h1, 1'b0);
    reg_is(12'h010, 32'h0, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'hff, r, e);
    chk("ro write", 32'(e), 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h1, r, e);
    reg_is(ADDR_CTRL, 32'h1, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0, r, e);
  endtask
  task automatic t_serial();
    logic [7:0] rx;
    i_dms_host_model.pulse();
    i_dms_host_model.frame(16'h000c, rx);
    chk("q aux", 32'(q_pin_is_aux), 32'h1);
    chk("i aux", 32'(i_pin_is_aux), 32'h1);
    i_dms_host_model.frame(16'h8000, rx);
    chk("serial read", 32'(rx), 32'h0c);
    i_dms_host_model.frame(16'h0503, rx);
    reg_is(ADDR_SPIREG, 32'h0c, 1'b0);
    i_dms_host_model.frame(16'h8500, rx);
    chk("bad index", 32'(rx), 32'h0);
    i_dms_host_model.frame(16'h000f, rx);
    chk("fmt reg", 32'(twos_complement), 32'h1);
    chk("pd reg", 32'(power_down), 32'h1);
  endtask
  task automatic t_mode_reset();
    i_dms_host_model.pulse();
    reg_is(ADDR_SPIREG, 32'h0, 1'b0);
    chk("q aux off", 32'(q_pin_is_aux), 32'h0);
  endtask
  task automatic t_straps();
    int t, w, c;
    for (int k = 0; k < 4; k++) begin
      pins(1'b1, 1'b0, k[0], k[1], t, w, c);
      chk("mode", 32'(serial_mode), 32'h0);
      chk("format", 32'(twos_complement), 32'(k[0]));
      chk("power", 32'(power_down), 32'(k[1]));
    end
  endtask
  task automatic t_retime();
    int t, w, c;
    logic [31:0] r;
    logic e;
    @(posedge clk) sampling_clock <= 1'b1;
    pins(1'b1, 1'b0, 1'b0, 1'b0, t, w, c);
    pins(1'b1, 1'b1, 1'b0, 1'b0, t, w, c);
    chk("trigger", 32'(t), 32'h1);
    chk("phase", 32'(retime_phase), 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h1, r, e);
    pins(1'b1, 1'b0, 1'b0, 1'b0, t, w, c);
    pins(1'b1, 1'b1, 1'b0, 1'b0, t, w, c);
    chk("shared clocks", 32'(t), 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h0, r, e);
  endtask
  task automatic t_data();
    int t, w, c;
    logic [DATA_W-1:0] d;
    // third pass powers down: nothing may move
    for (int f = 0; f < 3; f++) begin
      d = 14'h0123 + 14'(f);
      @(posedge clk) begin
        data_clock <= 1'b0;
        sampling_clock <= 1'b0;
        data_in <= d;
      end
      pins(1'b1, 1'b0, f[0], f[1], t, w, c);
      @(posedge clk) data_clock <= 1'b1;
      count16(t, w, c);
      chk("word", 32'(w), 32'(f < 2));
      @(posedge clk) sampling_clock <= 1'b1;
      count16(t, w, c);
      chk("strobe", 32'(c), 32'(f < 2));
      if (f < 2) begin
        chk("conv", 32'(conv_word),
          32'({f[0] ^ d[13], d[12:0]}));
      end
    end
    reg_is(ADDR_DATA, 32'h2124, 1'b0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_serial();
    t_mode_reset();
    t_straps();
    t_retime();
    t_data();
    conclude();
  end
endmodule // dms_mode_ctl_bench
